// [src/status_link_if.sv]
// Serial link between the microcontroller end and the status register end
`timescale 1ns/10ps
interface status_link_if;
    logic sclk;
    logic cs_b;
    logic mosi;
    logic miso;

    modport device
    (
        input sclk,
        input cs_b,
        input mosi,
        output miso
    );

    modport host
    (
        output sclk,
        output cs_b,
        output mosi,
        input miso
    );
endinterface

// [src/supply_status_defs.svh]
// Offsets, field positions, reset values and timing counts of the status register bank
`ifndef SUPPLY_STATUS_DEFS_SVH
`define SUPPLY_STATUS_DEFS_SVH

`define ADDR_SCRATCH 7'h1E
`define ADDR_SUPPLY_B 7'h40
`define ADDR_SUPPLY_A 7'h41
`define ADDR_THERMAL 7'h42

`define FRAME_BITS 16
`define FRAME_MODE_BIT 7
`define FRAME_DATA_LSB 8

`define SCRATCH_POR 8'h00
`define SUPPLY_B_POR 8'h00
`define SUPPLY_A_POR 8'h80
`define SUPPLY_A_SOFT 8'h00
`define THERMAL_POR 8'h00

`define SUPPLY_B_MASK 8'h5F
`define SUPPLY_A_MASK 8'hFF
`define THERMAL_MASK 8'h07

`define BIT_BATT_UV 6
`define BIT_EXT_OC 4
`define BIT_EXT_UV 3
`define BIT_EXT_OT 2
`define BIT_MAIN_OV 1
`define BIT_MAIN_WARN 0
`define BIT_POR 7
`define BIT_SW_UV 6
`define BIT_SW_OV 5
`define BIT_AUX_OT 4
`define BIT_AUX_UV 3
`define BIT_MAIN_SC 2
`define BIT_MAIN_UV_FS 1
`define BIT_MAIN_UV 0
`define BIT_SHUTDOWN_L2 2
`define BIT_SHUTDOWN_L1 1
`define BIT_PREWARN 0

`define SHORT_TIME_US 4000
`define CLK_MHZ 25
`define SHORT_CYCLES ((`SHORT_TIME_US * `CLK_MHZ) + 1)
`define UV_FAILSAFE_COUNT 4

`define SCLK_HALF_CYCLES 4

`endif

// [src/supply_status_device.sv]
// Status register end: scratch byte and sticky supply and thermal flags behind a serial link
//
// Summary of operation
// - Scratch zero on power-on, kept on soft reset
// - Scratch accessible only in Normal mode
// - Scratch kept through Fail-Safe and Restart
// - Frame: address, mode bit, data byte
// - Data bits sit at frame bits 8..15
// - Mode bit zero reads without change
// - Mode bit one clears whole status byte
// - Flags stay set until cleared
// - Reserved bits read as zero
// - Supply byte b: battery, external regulator flags
// - Supply byte b: main overvoltage and prewarning
// - Power-on flag set at POR, soft clears
// - Supply byte a: switch supply, aux regulator flags
// - Short flag after 4ms below threshold
// - Fourth undervoltage sets fail-safe flag
// - Sleep with regulator off sets no main flags except main warning
// - Main undervoltage update gated by mode
// - Thermal byte: level2, level1, prewarning flags
// - Thermal flags stay after condition ends
//
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
`include "supply_status_defs.svh"
module supply_status_device
    import supply_status_pkg::*;
#(
    parameter int SHORT_CYCLES = `SHORT_CYCLES
)
(
    input wire logic clk,
    input wire logic rst_b,
    status_link_if.device link,
    input wire logic soft_reset,
    input device_mode_t mode,
    input wire logic main_reg_on,
    input wire logic reset_output_released,
    input wire logic battery_uv,
    input wire logic ext_oc,
    input wire logic ext_uv,
    input wire logic ext_ot,
    input wire logic main_ov,
    input wire logic main_warn,
    input wire logic switch_uv,
    input wire logic switch_ov,
    input wire logic aux_ot,
    input wire logic aux_uv,
    input wire logic main_uv,
    input wire logic thermal_shutdown_level2,
    input wire logic thermal_shutdown_level1,
    input wire logic thermal_prewarning,
    output logic [7:0] scratch_config_byte,
    output logic failsafe_request
);
    if (SHORT_CYCLES < 1)
    begin
        $error("SHORT_CYCLES must be at least one");
    end

    // Link pins come from another domain: two flops before any use
    logic [2:0] sclk_s_q, cs_s_q;
    logic [1:0] mosi_s_q;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sclk_s_q <= 3'h0;
            cs_s_q <= 3'h7;
            mosi_s_q <= 2'h0;
        end
        else
        begin
            sclk_s_q <= {sclk_s_q[1:0], link.sclk};
            cs_s_q <= {cs_s_q[1:0], link.cs_b};
            mosi_s_q <= {mosi_s_q[0], link.mosi};
        end
    end
    wire sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
    wire sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];
    wire cs_active = ~cs_s_q[1];
    wire cs_end = cs_s_q[1] & ~cs_s_q[2];

    logic [15:0] rx_q;
    logic [4:0] bit_cnt_q;
    logic [7:0] tx_q;
    logic frame_ok;
    assign frame_ok = (bit_cnt_q == 5'h10);

    function automatic logic [7:0] status_of(input logic [6:0] addr, input logic [7:0] b,
                                             input logic [7:0] a, input logic [7:0] t,
                                             input logic [7:0] s);
        case (addr)
            `ADDR_SUPPLY_B: status_of = b & `SUPPLY_B_MASK;
            `ADDR_SUPPLY_A: status_of = a & `SUPPLY_A_MASK;
            `ADDR_THERMAL: status_of = t & `THERMAL_MASK;
            `ADDR_SCRATCH: status_of = s;
            default: status_of = 8'h00;
        endcase
    endfunction

    logic [7:0] supply_b_q, supply_a_q, thermal_q;

    // Frame bits arrive LSB first: address in 6:0, mode in 7, data in 15:8
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rx_q <= 16'h0000;
            bit_cnt_q <= 5'h00;
        end
        else if (!cs_active)
            bit_cnt_q <= 5'h00;
        else if (sclk_rise && bit_cnt_q != 5'h10)
        begin
            rx_q <= {mosi_s_q[1], rx_q[15:1]};
            bit_cnt_q <= bit_cnt_q + 5'h01;
        end
    end

    // Reply byte is latched once the address is in, before any clear lands
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            tx_q <= 8'h00;
        else if (sclk_rise && bit_cnt_q == 5'h07)
            tx_q <= status_of(rx_q[15:9], supply_b_q, supply_a_q, thermal_q,
                              (mode == MODE_NORMAL) ? scratch_config_byte : 8'h00);
        else if (sclk_fall && bit_cnt_q >= 5'h09)
            tx_q <= {1'b0, tx_q[7:1]};
    end
    // Header slots return zero; data slots shift the latched byte LSB first
    assign link.miso = (cs_active && bit_cnt_q >= 5'h08) ? tx_q[0] : 1'b0;

    wire [6:0] f_addr = rx_q[6:0];
    wire f_mode = rx_q[`FRAME_MODE_BIT];
    wire f_done = cs_end && frame_ok;
    wire clr_b = f_done && f_mode && f_addr == `ADDR_SUPPLY_B;
    wire clr_a = f_done && f_mode && f_addr == `ADDR_SUPPLY_A;
    wire clr_t = f_done && f_mode && f_addr == `ADDR_THERMAL;

    // Scratch: only the POR clears it; soft reset and mode changes leave it
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            scratch_config_byte <= `SCRATCH_POR;
        else if (f_done && f_mode && f_addr == `ADDR_SCRATCH && mode == MODE_NORMAL)
            scratch_config_byte <= rx_q[15:8];
    end

    wire main_live = !(mode == MODE_SLEEP && !main_reg_on);

    // Short detection: main undervoltage held past the limit after switch-on
    logic [31:0] short_cnt_q;
    logic short_hit;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            short_cnt_q <= 32'h0;
        else if (!main_reg_on || !main_uv)
            short_cnt_q <= 32'h0;
        else if (short_cnt_q < 32'(SHORT_CYCLES))
            short_cnt_q <= short_cnt_q + 32'h1;
    end
    assign short_hit = short_cnt_q >= 32'(SHORT_CYCLES);

    logic init_released_q;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            init_released_q <= 1'b0;
        else if (reset_output_released)
            init_released_q <= 1'b1;
    end

    logic uv_upd;
    always_comb
    begin
        case (mode)
            MODE_RESTART: uv_upd = short_hit;
            MODE_INIT: uv_upd = init_released_q | short_hit;
            MODE_NORMAL, MODE_STOP: uv_upd = 1'b1;
            default: uv_upd = short_hit;
        endcase
    end

    // Consecutive undervoltage events; fourth forces fail-safe
    logic main_uv_q;
    logic [2:0] uv_cnt_q;
    wire uv_event = main_uv && !main_uv_q && uv_upd && main_live;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            main_uv_q <= 1'b0;
            uv_cnt_q <= 3'h0;
        end
        else
        begin
            main_uv_q <= main_uv;
            if (soft_reset || mode == MODE_NORMAL && !main_uv)
                uv_cnt_q <= 3'h0;
            else if (uv_event && uv_cnt_q < 3'(`UV_FAILSAFE_COUNT))
                uv_cnt_q <= uv_cnt_q + 3'h1;
        end
    end
    wire uv_fs_hit = uv_event && uv_cnt_q == 3'(`UV_FAILSAFE_COUNT - 1);
    assign failsafe_request = thermal_shutdown_level2 | (uv_cnt_q == 3'(`UV_FAILSAFE_COUNT));

    logic [7:0] set_b, set_a, set_t;
    always_comb
    begin
        set_b = 8'h00;
        set_b[`BIT_BATT_UV] = battery_uv;
        set_b[`BIT_EXT_OC] = ext_oc;
        set_b[`BIT_EXT_UV] = ext_uv;
        set_b[`BIT_EXT_OT] = ext_ot;
        set_b[`BIT_MAIN_OV] = main_ov & main_live;
        set_b[`BIT_MAIN_WARN] = main_warn;
        set_a = 8'h00;
        set_a[`BIT_SW_UV] = switch_uv;
        set_a[`BIT_SW_OV] = switch_ov;
        set_a[`BIT_AUX_OT] = aux_ot;
        set_a[`BIT_AUX_UV] = aux_uv;
        set_a[`BIT_MAIN_SC] = short_hit & main_live;
        set_a[`BIT_MAIN_UV_FS] = uv_fs_hit;
        set_a[`BIT_MAIN_UV] = main_uv & uv_upd & main_live;
        set_t = 8'h00;
        set_t[`BIT_SHUTDOWN_L2] = thermal_shutdown_level2;
        set_t[`BIT_SHUTDOWN_L1] = thermal_shutdown_level1;
        set_t[`BIT_PREWARN] = thermal_prewarning;
    end

    // Sticky flags: set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            supply_b_q <= `SUPPLY_B_POR;
            supply_a_q <= `SUPPLY_A_POR;
            thermal_q <= `THERMAL_POR;
        end
        else if (soft_reset)
        begin
            supply_b_q <= `SUPPLY_B_POR;
            supply_a_q <= `SUPPLY_A_SOFT;
            thermal_q <= `THERMAL_POR;
        end
        else
        begin
            supply_b_q <= ((clr_b ? 8'h00 : supply_b_q) | set_b) & `SUPPLY_B_MASK;
            supply_a_q <= (clr_a ? 8'h00 : supply_a_q) | set_a;
            thermal_q <= ((clr_t ? 8'h00 : thermal_q) | set_t) & `THERMAL_MASK;
        end
    end
endmodule

// [src/supply_status_host.sv]
// Microcontroller end: drives one 16-bit frame per command and returns the reply byte
`timescale 1ns/10ps
`include "supply_status_defs.svh"
module supply_status_host
    import supply_status_pkg::*;
#(
    parameter int HALF_CYCLES = `SCLK_HALF_CYCLES
)
(
    input wire logic clk,
    input wire logic rst_b,
    status_link_if.host link,
    input wire logic [6:0] addr,
    input wire logic wr,
    input wire logic [7:0] wdata,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic busy
);
    // Far end needs four clocks per phase to sample; the divider is eight bits wide
    if (HALF_CYCLES < 4 || HALF_CYCLES > 256)
    begin
        $error("HALF_CYCLES must lie between 4 and 256");
    end

    host_state_t state_q;
    logic [15:0] frame_q;
    logic [7:0] rx_q;
    logic [4:0] bit_q;
    logic [7:0] div_q;
    logic sclk_q, cs_b_q, miso_s1_q, miso_s2_q;
    wire tick = (div_q == 8'(HALF_CYCLES - 1));

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            miso_s1_q <= 1'b0;
            miso_s2_q <= 1'b0;
        end
        else
        begin
            miso_s1_q <= link.miso;
            miso_s2_q <= miso_s1_q;
        end
    end

    // Start: wr sends mode bit 1 (write scratch / clear status), rd sends mode bit 0
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= HOST_IDLE;
            frame_q <= 16'h0000;
            rx_q <= 8'h00;
            bit_q <= 5'h00;
            div_q <= 8'h00;
            sclk_q <= 1'b0;
            cs_b_q <= 1'b1;
            rdata <= 8'h00;
        end
        else
        begin
            case (state_q)
                HOST_IDLE:
                begin
                    div_q <= 8'h00;
                    if (wr || rd)
                    begin
                        frame_q <= {wdata, wr, addr};
                        cs_b_q <= 1'b0;
                        bit_q <= 5'h00;
                        state_q <= HOST_SHIFT;
                    end
                end
                HOST_SHIFT:
                begin
                    div_q <= tick ? 8'h00 : div_q + 8'h01;
                    if (tick)
                    begin
                        sclk_q <= ~sclk_q;
                        if (sclk_q)
                        begin
                            // Take the bit at the fall: the far end moves on only after
                            // its own syncer sees this edge, so the synced line still holds it
                            if (bit_q >= 5'h08)
                                rx_q <= {miso_s2_q, rx_q[7:1]};
                            frame_q <= {1'b0, frame_q[15:1]};
                            bit_q <= bit_q + 5'h01;
                            if (bit_q == 5'h0F)
                                state_q <= HOST_DONE;
                        end
                    end
                end
                HOST_DONE:
                begin
                    div_q <= tick ? 8'h00 : div_q + 8'h01;
                    if (tick)
                    begin
                        cs_b_q <= 1'b1;
                        rdata <= rx_q;
                        state_q <= HOST_IDLE;
                    end
                end
                default: state_q <= HOST_IDLE;
            endcase
        end
    end

    assign link.sclk = sclk_q;
    assign link.cs_b = cs_b_q;
    assign link.mosi = frame_q[0];
    assign busy = (state_q != HOST_IDLE);
endmodule

// [src/supply_status_pkg.sv]
// Types shared by both ends of the status register link
package supply_status_pkg;

    typedef enum logic [2:0]
    {
        MODE_INIT = 3'b000,
        MODE_NORMAL = 3'b001,
        MODE_STOP = 3'b010,
        MODE_SLEEP = 3'b011,
        MODE_RESTART = 3'b100,
        MODE_FAILSAFE = 3'b101
    } device_mode_t;

    typedef enum logic [1:0]
    {
        HOST_IDLE = 2'b00,
        HOST_SHIFT = 2'b01,
        HOST_DONE = 2'b10
    } host_state_t;

endpackage

// [verification/supply_status_checker.sv]
// Link protocol checker watching the serial lines between host and status register end
`timescale 1ns/10ps
module supply_status_checker
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic cs_b,
    input wire logic mosi,
    input wire logic miso
);
    logic sclk_q;
    logic [4:0] rises_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            sclk_q <= 1'b0;
        else
            sclk_q <= sclk;
    end

    // Rising link edges seen so far in the open frame
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rises_q <= 5'h00;
        else if (cs_b)
            rises_q <= 5'h00;
        else if (sclk && !sclk_q)
            rises_q <= rises_q + 5'h01;
    end

    a_sclk_idle_low: assert property (cs_b |-> !sclk)
        else $error("link clock not low outside a frame");
    a_miso_idle_zero: assert property (cs_b |-> !miso)
        else $error("reply line not quiet outside a frame");
    a_sclk_high_half: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
        else $error("link clock high phase has wrong length");
    a_sclk_low_half: assert property ($fell(sclk) |-> !sclk [*4])
        else $error("link clock low phase too short");
    a_cs_lead_time: assert property ($fell(cs_b) |-> !sclk ##[1:8] $rose(sclk))
        else $error("first link clock edge late or early");
    a_frame_sixteen: assert property ($rose(cs_b) |-> rises_q == 5'h10)
        else $error("frame did not carry sixteen bits");
    a_cs_held_frame: assert property (!cs_b && rises_q < 5'h10 |=> !cs_b)
        else $error("select released inside a frame");
    a_miso_head_zero: assert property (!cs_b && rises_q < 5'h08 |-> !miso)
        else $error("reply data outside the data byte slots");
    a_mosi_stable_high: assert property (!cs_b && sclk && sclk_q |-> $stable(mosi))
        else $error("command line moved while link clock high");
endmodule

// [verification/supply_status_regs_bench.sv]
// Self-checking bench: host end and status register end joined over the serial link
`timescale 1ns/10ps
`include "supply_status_defs.svh"
module supply_thermal_status_regs_bench;
    import supply_status_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [6:0] addr = 7'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic busy;
    logic soft_reset = 1'b0;
    device_mode_t mode = MODE_INIT;
    logic main_reg_on = 1'b1;
    logic rst_out_rel = 1'b0;
    logic [13:0] cond = 14'h0000;
    logic [7:0] scratch;
    logic fs_req;
    logic [7:0] mdl [0:127];
    int fails = 0;
    int checks_done = 0;
    int seed = 32'h5F22BF36;
    // Register and bit of each condition input, in cond order
    int c_addr [0:13] = '{64, 64, 64, 64, 64, 64, 65, 65, 65, 65, 65, 66, 66, 66};
    int c_bit [0:13] = '{6, 4, 3, 2, 1, 0, 6, 5, 4, 3, 0, 2, 1, 0};

    status_link_if lnk();
    supply_status_host i_supply_status_host
    (
        .clk(clk), .rst_b(rst_b), .link(lnk), .addr(addr), .wr(wr), .wdata(wdata),
        .rd(rd), .rdata(rdata), .busy(busy)
    );
    // Short-circuit time cut to 20 cycles to keep the run brief
    supply_status_device #(.SHORT_CYCLES(20)) i_supply_status_device
    (
        .clk(clk), .rst_b(rst_b), .link(lnk), .soft_reset(soft_reset), .mode(mode),
        .main_reg_on(main_reg_on), .reset_output_released(rst_out_rel),
        .battery_uv(cond[0]), .ext_oc(cond[1]), .ext_uv(cond[2]), .ext_ot(cond[3]),
        .main_ov(cond[4]), .main_warn(cond[5]), .switch_uv(cond[6]), .switch_ov(cond[7]),
        .aux_ot(cond[8]), .aux_uv(cond[9]), .main_uv(cond[10]),
        .thermal_shutdown_level2(cond[11]), .thermal_shutdown_level1(cond[12]),
        .thermal_prewarning(cond[13]), .scratch_config_byte(scratch),
        .failsafe_request(fs_req)
    );
    supply_status_checker i_chk
    (
        .clk(clk), .rst_b(rst_b), .sclk(lnk.sclk), .cs_b(lnk.cs_b), .mosi(lnk.mosi),
        .miso(lnk.miso)
    );

    always #20 clk = ~clk;

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One full frame; the reply, except to a scratch write, is compared with the model before it is updated
    task automatic op(input logic [6:0] a, input logic w, input logic [7:0] d);
        logic [7:0] e;
        int n;
        e = (a == `ADDR_SCRATCH && mode != MODE_NORMAL) ? 8'h00 : mdl[a];
        n = 0;
        @(posedge clk);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        @(negedge clk);
        while (busy !== 1'b0 && n < 400)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 400)
        begin
            fails++;
            $display("[ERR] %0t link frame never ended", $time);
        end
        if (!(a == `ADDR_SCRATCH && w))
            chk(rdata, e);
        if (w && a != `ADDR_SCRATCH)
            mdl[a] = 8'h00;
        else if (w && mode == MODE_NORMAL)
            mdl[a] = d;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic hit(input int i, input logic en);
        @(posedge clk);
        cond <= 14'h0001 << i;
        @(posedge clk);
        cond <= 14'h0000;
        if (en)
            mdl[c_addr[i]][c_bit[i]] = 1'b1;
        repeat (3) @(posedge clk);
    endtask

    task automatic set_mode(input device_mode_t m);
        @(posedge clk);
        mode <= m;
        @(posedge clk);
    endtask

    initial
    begin
        repeat (30000) @(posedge clk);
        fails++;
        end_sim();
    end

    initial
    begin
        logic [7:0] d;
        for (int k = 0; k < 128; k++)
            mdl[k] = 8'h00;
        mdl[65] = 8'h80;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        foreach (c_addr[k])
            if (k < 3)
                op(7'(64 + k), 1'b0, 8'($random(seed)));
        op(`ADDR_SCRATCH, 1'b0, 8'h00);
        op(7'h10, 1'b0, 8'h00);
        op(7'h10, 1'b1, 8'hFF);
        chk(scratch, 8'h00);
        $display("reset values done");
        hit(10, 1'b0);
        op(7'h41, 1'b0, 8'h00);
        @(posedge clk);
        rst_out_rel <= 1'b1;
        hit(10, 1'b1);
        op(7'h41, 1'b1, 8'h00);
        $display("init gating done");
        set_mode(MODE_NORMAL);
        d = 8'($random(seed));
        op(`ADDR_SCRATCH, 1'b1, d);
        chk(scratch, d);
        op(`ADDR_SCRATCH, 1'b0, 8'h00);
        set_mode(MODE_STOP);
        op(`ADDR_SCRATCH, 1'b0, 8'h00);
        op(`ADDR_SCRATCH, 1'b1, ~d);
        chk(scratch, d);
        set_mode(MODE_FAILSAFE);
        set_mode(MODE_RESTART);
        chk(scratch, d);
        set_mode(MODE_NORMAL);
        hit(13, 1'b1);
        @(posedge clk);
        soft_reset <= 1'b1;
        @(posedge clk);
        soft_reset <= 1'b0;
        mdl[64] = 8'h00;
        mdl[65] = 8'h00;
        mdl[66] = 8'h00;
        chk(scratch, d);
        op(7'h41, 1'b0, 8'h00);
        op(7'h42, 1'b0, 8'h00);
        $display("scratch and soft reset done");
        foreach (c_addr[i])
        begin
            hit(i, 1'b1);
            op(7'(c_addr[i]), 1'b0, 8'($random(seed)));
            op(7'(c_addr[i]), 1'b1, 8'($random(seed)));
            op(7'(c_addr[i]), 1'b0, 8'($random(seed)));
        end
        $display("flag table done");
        set_mode(MODE_SLEEP);
        main_reg_on <= 1'b0;
        hit(4, 1'b0);
        hit(10, 1'b0);
        op(7'h40, 1'b0, 8'h00);
        op(7'h41, 1'b0, 8'h00);
        set_mode(MODE_RESTART);
        main_reg_on <= 1'b1;
        hit(10, 1'b0);
        op(7'h41, 1'b0, 8'h00);
        $display("mode gating done");
        set_mode(MODE_NORMAL);
        set_mode(MODE_STOP);
        repeat (4) hit(10, 1'b1);
        mdl[65][1] = 1'b1;
        chk({7'h00, fs_req}, 8'h01);
        op(7'h41, 1'b1, 8'h00);
        set_mode(MODE_NORMAL);
        $display("fail-safe count done");
        @(posedge clk);
        cond <= 14'h0400;
        repeat (40) @(posedge clk);
        cond <= 14'h0000;
        mdl[65] = 8'h05;
        op(7'h41, 1'b0, 8'h00);
        op(7'h41, 1'b1, 8'h00);
        $display("short detect done");
        end_sim();
    end
endmodule
